// ### hw/ac_regs.sv
// Register set and data steering for the link-layer AES engine.
// Assumes an APB master on pclk, a cipher core with word streams and event pulses
// on the same clock, and a link-layer packet path that honours valid and ready.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// - Packet AES traffic flows only while enable bit 0 is one; resets to zero.
// - Control bit 16 selects little (0) or big (1) endian packet words.
// - Control bit 11 selects little (0) or big (1) endian engine output.
// - Control bit 9 selects little (0) or big (1) endian key interpretation.
// - Control bit 8 selects little (0) or big (1) endian input data.
// - Length register holds packet length [15:8] and associated length [7:0].
// - Four-bit interrupt mask: encrypt done, decrypt fail, decrypt ok, single done.
module ac_regs
  import ac_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // APB slave port.
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Settings driven to the cipher core.
  output logic                   eng_enable,
  output logic                   eng_single_mode,
  output logic                   eng_decrypt,
  output logic                   eng_xor_sel,
  output logic [LEN_W-1:0]       eng_packet_len,
  output logic [LEN_W-1:0]       eng_aad_len,
  // Key and single-block data, and their byte-ordered forms for the core.
  input  wire logic [127:0]      key_in,
  input  wire logic [127:0]      blk_in,
  output logic [127:0]           eng_key,
  output logic [127:0]           eng_blk_in,
  // Event pulses from the cipher core.
  input  wire logic              evt_encrypt_done,
  input  wire logic              evt_decrypt_fail,
  input  wire logic              evt_decrypt_ok,
  input  wire logic              evt_single_done,
  // Packet words from the link layer toward the core.
  input  wire logic              pkt_in_valid,
  input  wire logic [DATA_W-1:0] pkt_in_data,
  output logic                   pkt_in_ready,
  output logic                   eng_pkt_valid,
  output logic [DATA_W-1:0]      eng_pkt_data,
  input  wire logic              eng_pkt_ready,
  // Result words from the core toward the link layer.
  input  wire logic              eng_res_valid,
  input  wire logic [DATA_W-1:0] eng_res_data,
  output logic                   eng_res_ready,
  output logic                   pkt_out_valid,
  output logic [DATA_W-1:0]      pkt_out_data,
  input  wire logic              pkt_out_ready
);

  // The decoder compares against twelve-bit offsets and the data path needs bytes.
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ac_regs address must cover the twelve decoded bits");
  end
  if (DATA_W < 8 || (DATA_W % 8) != 0) begin : g_bad_data
    $error("ac_regs packet words must be whole bytes");
  end

  // Software-visible state.
  logic              enable;
  logic [31:0]       control;
  logic [LEN_W-1:0]  plen;
  logic [LEN_W-1:0]  aad;
  logic [IRQ_W-1:0]  imask;
  logic [IRQ_W-1:0]  istat;
  logic [IRQ_W-1:0]  next_istat;

  // Bus decode results.
  logic              setup_phase;
  logic              access_phase;
  logic              wr_access;
  logic              addr_hit;
  logic [11:0]       offset;
  logic [IRQ_W-1:0]  event_set;
  logic [IRQ_W-1:0]  event_clr;

  // Internal packet-path handshakes between the gate and the swap stages.
  logic              pdu_in_valid;
  logic              pdu_in_ready;
  logic              res_mid_valid;
  logic [DATA_W-1:0] res_mid_data;
  logic              res_mid_ready;
  logic              out_stage_ready;

  // Tells whether a byte offset falls on one of the mapped registers.
  function automatic logic is_mapped(input logic [11:0] off);
    logic hit;
    hit = 1'b0;
    unique case (off)
      OFF_ENABLE, OFF_CONTROL, OFF_SPARE, OFF_LENGTH, OFF_IMASK, OFF_ISTAT: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Builds the read word for a mapped offset; reserved bits read zero.
  function automatic logic [31:0] read_word(input logic [11:0] off);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (off)
      OFF_ENABLE: begin
        w[ENABLE_BIT] = enable;
      end
      OFF_CONTROL: begin
        w = control & CTL_WMASK;
      end
      OFF_LENGTH: begin
        w[LEN_PLEN_LSB +: LEN_W] = plen;
        w[LEN_AAD_LSB +: LEN_W]  = aad;
      end
      OFF_IMASK: begin
        w[IRQ_W-1:0] = imask;
      end
      OFF_ISTAT: begin
        w[IRQ_W-1:0] = istat;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  // Only the low twelve address bits select a register; word alignment is implied.
  assign offset       = {paddr[11:2], 2'b00};
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_hit     = is_mapped(offset);
  assign wr_access    = access_phase & pwrite & addr_hit;

  // Every access completes with no wait state; unmapped offsets report an error.
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~addr_hit;

  // Read data is captured in the setup cycle so it comes from a register in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_word(offset);
    end
  end

  // Global enable for packet processing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= RST_ENABLE;
    end else if (wr_access && offset == OFF_ENABLE) begin
      enable <= pwdata[ENABLE_BIT];
    end
  end

  // Control register; reserved bits are never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= RST_CONTROL;
    end else if (wr_access && offset == OFF_CONTROL) begin
      control <= pwdata & CTL_WMASK;
    end
  end

  // Packet length and associated-data length fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plen <= RST_LEN;
      aad  <= RST_LEN;
    end else if (wr_access && offset == OFF_LENGTH) begin
      plen <= pwdata[LEN_PLEN_LSB +: LEN_W];
      aad  <= pwdata[LEN_AAD_LSB +: LEN_W];
    end
  end

  // Interrupt mask, one bit per event source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask <= RST_IMASK;
    end else if (wr_access && offset == OFF_IMASK) begin
      imask <= pwdata[IRQ_W-1:0];
    end
  end

  // Events from the core; packet events count only while packet processing runs.
  always_comb begin
    event_set                  = '0;
    event_set[IRQ_ENC_DONE]    = evt_encrypt_done & enable;
    event_set[IRQ_DEC_FAIL]    = evt_decrypt_fail & enable;
    event_set[IRQ_DEC_OK]      = evt_decrypt_ok & enable;
    event_set[IRQ_SINGLE_DONE] = evt_single_done;
  end

  // Writing a one to a status bit clears it.
  assign event_clr = (wr_access && offset == OFF_ISTAT) ? pwdata[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives, because the set term is applied last.
  assign next_istat = (istat & ~event_clr) | event_set;

  // Sticky interrupt status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= RST_ISTAT;
    end else begin
      istat <= next_istat;
    end
  end

  // One level interrupt while any enabled status bit stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_istat & imask);
    end
  end

  // Mode and length settings toward the core, all straight from registers.
  assign eng_enable      = enable;
  assign eng_single_mode = control[CTL_SINGLE];
  assign eng_decrypt     = control[CTL_DECRYPT];
  assign eng_xor_sel     = control[CTL_XOR];
  assign eng_packet_len  = plen;
  assign eng_aad_len     = aad;

  // Key and block data in the order the core expects, re-registered each cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_key    <= 128'h0;
      eng_blk_in <= 128'h0;
    end else begin
      eng_key    <= control[CTL_KEY_BE] ? ac_rev128(key_in) : key_in;
      eng_blk_in <= control[CTL_DIN_BE] ? ac_rev128(blk_in) : blk_in;
    end
  end

  // Link-layer words pass to the core only while packet processing is enabled.
  assign pdu_in_valid = pkt_in_valid & enable;
  assign pkt_in_ready = pdu_in_ready & enable;

  // Packet words toward the core take the packet byte order.
  ac_swap #(
    .W          (DATA_W)
  ) u_pdu_in (
    .pclk       (pclk),
    .presetn    (presetn),
    .big_endian (control[CTL_PDU_BE]),
    .in_valid   (pdu_in_valid),
    .in_data    (pkt_in_data),
    .in_ready   (pdu_in_ready),
    .out_valid  (eng_pkt_valid),
    .out_data   (eng_pkt_data),
    .out_ready  (eng_pkt_ready)
  );

  // Core results first take the output byte order.
  ac_swap #(
    .W          (DATA_W)
  ) u_res_out (
    .pclk       (pclk),
    .presetn    (presetn),
    .big_endian (control[CTL_OUT_BE]),
    .in_valid   (eng_res_valid),
    .in_data    (eng_res_data),
    .in_ready   (eng_res_ready),
    .out_valid  (res_mid_valid),
    .out_data   (res_mid_data),
    .out_ready  (res_mid_ready)
  );

  // Packet results leave toward the link in packet byte order; single-block results
  // bypass that reordering since they never belong to a packet.
  logic res_pdu_be;
  assign res_pdu_be = control[CTL_PDU_BE] & ~control[CTL_SINGLE];

  // Results reach the link only while enabled or when the core runs single blocks.
  logic res_pass;
  assign res_pass      = enable | control[CTL_SINGLE];
  assign res_mid_ready = out_stage_ready & res_pass;

  ac_swap #(
    .W          (DATA_W)
  ) u_pdu_out (
    .pclk       (pclk),
    .presetn    (presetn),
    .big_endian (res_pdu_be),
    .in_valid   (res_mid_valid & res_pass),
    .in_data    (res_mid_data),
    .in_ready   (out_stage_ready),
    .out_valid  (pkt_out_valid),
    .out_data   (pkt_out_data),
    .out_ready  (pkt_out_ready)
  );

endmodule

// ### hw/ac_swap.sv
// Registered byte-order stage for one stream of words with valid and ready.
// Assumes the same clock as its user; big_endian is a static setting from a register.
`timescale 1ns/100ps
module ac_swap
  import ac_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         big_endian,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  // Byte reversal needs whole bytes.
  if (W < 8 || (W % 8) != 0) begin : g_bad_width
    $error("ac_swap width must be a whole number of bytes");
  end

  // Reverses the byte order of one word of this stage's width.
  function automatic logic [W-1:0] rev_bytes(input logic [W-1:0] d);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W/8; i++) begin
      r[8*i +: 8] = d[8*(W/8-1-i) +: 8];
    end
    return r;
  endfunction

  // The stage takes a new word whenever it is empty or its word is leaving.
  assign in_ready = ~out_valid | out_ready;

  // Holds the flag that a converted word waits at the output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
    end else if (in_valid && in_ready) begin
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // Captures the word, reversed when the big-endian order is selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data <= '0;
    end else if (in_valid && in_ready) begin
      out_data <= big_endian ? rev_bytes(in_data) : in_data;
    end
  end

endmodule

// ### include/ac_pkg.sv
// Shared constants for the link-layer AES register block and its byte-order stages.
// Assumes a 32-bit APB register bus and one clock domain for all users of this package.
package ac_pkg;

  // Register byte offsets within the block.
  localparam logic [11:0] OFF_ENABLE  = 12'h000;
  localparam logic [11:0] OFF_CONTROL = 12'h004;
  localparam logic [11:0] OFF_SPARE   = 12'h008;
  localparam logic [11:0] OFF_LENGTH  = 12'h00c;
  localparam logic [11:0] OFF_IMASK   = 12'h010;
  localparam logic [11:0] OFF_ISTAT   = 12'h014;

  // Field positions in the enable and control registers.
  localparam int ENABLE_BIT  = 0;
  localparam int CTL_PDU_BE  = 16;
  localparam int CTL_OUT_BE  = 11;
  localparam int CTL_XOR     = 10;
  localparam int CTL_KEY_BE  = 9;
  localparam int CTL_DIN_BE  = 8;
  localparam int CTL_SINGLE  = 4;
  localparam int CTL_DECRYPT = 3;

  // Writable bits of the control register; all others are reserved and read zero.
  localparam logic [31:0] CTL_WMASK = 32'h00010f18;

  // Field positions in the length register.
  localparam int LEN_W        = 8;
  localparam int LEN_PLEN_LSB = 8;
  localparam int LEN_AAD_LSB  = 0;

  // Interrupt source positions, shared by the mask and status registers.
  localparam int IRQ_W           = 4;
  localparam int IRQ_ENC_DONE    = 0;
  localparam int IRQ_DEC_FAIL    = 1;
  localparam int IRQ_DEC_OK      = 2;
  localparam int IRQ_SINGLE_DONE = 3;

  // Values after reset.
  localparam logic              RST_ENABLE  = 1'b0;
  localparam logic [31:0]       RST_CONTROL = 32'h00000000;
  localparam logic [LEN_W-1:0]  RST_LEN     = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IMASK   = 4'h0;
  localparam logic [IRQ_W-1:0]  RST_ISTAT   = 4'h0;

  // Reverses the byte order of a 128-bit word, used for key and block data.
  function automatic logic [127:0] ac_rev128(input logic [127:0] d);
    logic [127:0] r;
    r = 128'h0;
    for (int i = 0; i < 16; i++) begin
      r[8*i +: 8] = d[8*(15-i) +: 8];
    end
    return r;
  endfunction

endpackage

// ### test/ac_link_model.sv
// Link-layer packet path model: offers words to the block and sinks its results.
// Assumes the block's pclk; the stall input holds back the result sink.
`timescale 1ns/100ps
module ac_link_model (
  input  wire logic   pclk,
  input  wire logic   pkt_in_ready,
  output logic        pkt_in_valid,
  output logic [31:0] pkt_in_data,
  input  wire logic   stall,
  output logic        pkt_out_ready
);
  // The sink refuses results while stalled.
  assign pkt_out_ready = !stall;

  // Starts idle.
  initial begin
    pkt_in_valid = 1'b0;
    pkt_in_data  = 32'h0;
  end

  // Offers one word until taken, then shows its inverse so stale data never looks valid.
  task automatic send(input logic [31:0] w, output logic ok);
    int n;
    n = 0;
    pkt_in_valid <= 1'b1;
    pkt_in_data  <= w;
    @(posedge pclk);
    while (pkt_in_ready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    ok = (pkt_in_ready === 1'b1);
    pkt_in_valid <= 1'b0;
    pkt_in_data  <= ~w;
  endtask
endmodule

// ### test/ac_regs_properties.sv
// Assertions on the ports of the AES register block: register writes, streams, irq.
// Assumes one pclk domain with presetn active low; bound to every ac_regs instance.
`timescale 1ns/100ps
module ac_regs_properties
  import ac_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire logic              eng_enable,
  input wire logic              eng_single_mode,
  input wire logic              eng_decrypt,
  input wire logic [LEN_W-1:0]  eng_packet_len,
  input wire logic [LEN_W-1:0]  eng_aad_len,
  input wire logic [127:0]      key_in,
  input wire logic [127:0]      eng_key,
  input wire logic              pkt_in_valid,
  input wire logic [DATA_W-1:0] pkt_in_data,
  input wire logic              pkt_in_ready,
  input wire logic              eng_pkt_valid,
  input wire logic [DATA_W-1:0] eng_pkt_data,
  input wire logic              eng_pkt_ready,
  input wire logic              pkt_out_valid,
  input wire logic [DATA_W-1:0] pkt_out_data,
  input wire logic              pkt_out_ready
);
  // Decodes the write access phase and the word index it targets.
  logic       wr_acc;
  logic [9:0] widx;
  assign wr_acc = psel && penable && pwrite;
  assign widx   = paddr[11:2];

  // Reverses the byte order of a stream word.
  function automatic logic [DATA_W-1:0] sw(input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      r[8*i +: 8] = x[8*(DATA_W/8-1-i) +: 8];
    end
    return r;
  endfunction

  // Reverses the byte order of a key.
  function automatic logic [127:0] sw128(input logic [127:0] x);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[8*i +: 8] = x[8*(15-i) +: 8];
    end
    return r;
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ENABLE_WR: assert property (wr_acc && widx == 10'h0 |=>
    ##1 eng_enable == $past(pwdata[ENABLE_BIT], 2)) else $error("enable setting wrong");
  AST_CTRL_WR: assert property (wr_acc && widx == 10'h1 |=> ##1
    {eng_single_mode, eng_decrypt} == $past({pwdata[CTL_SINGLE], pwdata[CTL_DECRYPT]}, 2))
    else $error("mode settings wrong");
  AST_LEN_WR: assert property (wr_acc && widx == 10'h3 |=>
    ##1 {eng_packet_len, eng_aad_len} == $past(pwdata[15:0], 2)) else $error("lengths wrong");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("irq dropped without a write");
  AST_IN_GATE: assert property (pkt_in_ready |-> eng_enable)
    else $error("packet word accepted while disabled");
  AST_IN_PATH: assert property (pkt_in_valid && pkt_in_ready |=> eng_pkt_valid &&
    (eng_pkt_data == $past(pkt_in_data) || eng_pkt_data == sw($past(pkt_in_data))))
    else $error("packet word lost or mangled");
  AST_IN_HOLD: assert property (eng_pkt_valid && !eng_pkt_ready |=>
    eng_pkt_valid && $stable(eng_pkt_data)) else $error("core word not held");
  AST_OUT_HOLD: assert property (pkt_out_valid && !pkt_out_ready |=>
    pkt_out_valid && $stable(pkt_out_data)) else $error("result word not held");
  AST_KEY_ORDER: assert property ($past(presetn) |->
    eng_key == $past(key_in) || eng_key == sw128($past(key_in))) else $error("key mangled");
  AST_SLVERR: assert property (psel && penable && widx > 10'h5 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule

bind ac_regs ac_regs_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ac_regs_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .irq, .eng_enable,
  .eng_single_mode, .eng_decrypt, .eng_packet_len, .eng_aad_len, .key_in, .eng_key,
  .pkt_in_valid, .pkt_in_data, .pkt_in_ready, .eng_pkt_valid, .eng_pkt_data, .eng_pkt_ready,
  .pkt_out_valid, .pkt_out_data, .pkt_out_ready);

// ### test/ac_regs_tb.sv
// Self-checking bench for the AES register block: APB tasks and directed sequences.
// Assumes ac_regs with default parameters and the link model on its packet side.
`timescale 1ns/100ps
module ac_regs_tb;
  import ac_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, stall;
  logic         en, sm, dec, xs, pkt_in_valid, pkt_in_ready, eng_pkt_valid, eng_pkt_ready;
  logic         eng_res_valid, eng_res_ready, pkt_out_valid, pkt_out_ready;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, pkt_in_data, eng_pkt_data, eng_res_data, pkt_out_data;
  logic [7:0]   plen, alen;
  logic [3:0]   evt;
  logic [127:0] key_in, blk_in, eng_key, eng_blk_in;
  int           n_fail = 0;
  int           check_count = 0;

  ac_regs ac_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .eng_enable(en), .eng_single_mode(sm), .eng_decrypt(dec),
    .eng_xor_sel(xs), .eng_packet_len(plen), .eng_aad_len(alen), .key_in, .blk_in, .eng_key,
    .eng_blk_in, .evt_encrypt_done(evt[0]), .evt_decrypt_fail(evt[1]),
    .evt_decrypt_ok(evt[2]), .evt_single_done(evt[3]), .pkt_in_valid, .pkt_in_data,
    .pkt_in_ready, .eng_pkt_valid, .eng_pkt_data, .eng_pkt_ready, .eng_res_valid,
    .eng_res_data, .eng_res_ready, .pkt_out_valid, .pkt_out_data, .pkt_out_ready);
  ac_link_model ac_link_model_inst (.pclk, .pkt_in_ready, .pkt_in_valid, .pkt_in_data,
    .stall, .pkt_out_ready);

  // Reports the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge where pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Sends a link word and checks what reaches the core one cycle later.
  task automatic pkt_word(input logic [31:0] w, input logic [31:0] exp);
    logic ok;
    @(posedge pclk);
    ac_link_model_inst.send(w, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    #1;
    chk(eng_pkt_valid, 1'b1);
    chk(eng_pkt_data, exp);
  endtask

  // Hands a core result over with the link stalled, checks it, then lets it drain.
  task automatic res_word(input logic [31:0] w, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge pclk);
    stall         <= 1'b1;
    eng_res_valid <= 1'b1;
    eng_res_data  <= w;
    @(posedge pclk);
    while (eng_res_ready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (eng_res_ready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    eng_res_valid <= 1'b0;
    eng_res_data  <= ~w;
    repeat (4) @(posedge pclk);
    #1;
    chk({pkt_out_valid, pkt_out_data}, {1'b1, exp});
    @(posedge pclk);
    stall <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(pkt_out_valid, 1'b0);
  endtask

  // Pulses core events for one cycle and lets status and irq settle.
  task automatic pulse(input logic [3:0] v);
    @(posedge pclk);
    evt <= v;
    @(posedge pclk);
    evt <= 4'h0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Runs the clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, stall, eng_res_valid, evt} = '0;
    {paddr, pwdata, eng_res_data} = '0;
    eng_pkt_ready = 1'b1;
    key_in = 128'h00112233445566778899aabbccddeeff;
    blk_in = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdc(12'(4 * i), 32'h0);
    end
    rdc(12'h040, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, OFF_CONTROL, 32'hffffffff);
    rdc(OFF_CONTROL, 32'h00010f18);
    chk({sm, dec, xs}, 3'b111);
    chk(eng_key, 128'hffeeddccbbaa99887766554433221100);
    chk(eng_blk_in, 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f);
    apb(1'b1, OFF_SPARE, 32'hffffffff);
    rdc(OFF_SPARE, 32'h0);
    apb(1'b1, OFF_LENGTH, 32'hffffa55a);
    rdc(OFF_LENGTH, 32'h0000a55a);
    chk({plen, alen}, 16'ha55a);
    apb(1'b1, OFF_CONTROL, 32'h00000800);
    rdc(OFF_CONTROL, 32'h00000800);
    chk({sm, dec, xs}, 3'b000);
    chk(eng_key, key_in);
    chk(eng_blk_in, blk_in);
    chk({en, pkt_in_ready}, 2'b00);
    pulse(4'h7);
    rdc(OFF_ISTAT, 32'h0);
    apb(1'b1, OFF_ENABLE, 32'h1);
    pkt_word(32'h01020304, 32'h01020304);
    // The core stalls: the word must stand and the link must be held off.
    @(posedge pclk);
    eng_pkt_ready <= 1'b0;
    pkt_word(32'h05060708, 32'h05060708);
    repeat (2) @(posedge pclk);
    #1;
    chk({eng_pkt_valid, pkt_in_ready, eng_pkt_data}, {2'b10, 32'h05060708});
    @(posedge pclk);
    eng_pkt_ready <= 1'b1;
    res_word(32'ha1b2c3d4, 32'hd4c3b2a1);
    apb(1'b1, OFF_CONTROL, 32'h00010000);
    pkt_word(32'h01020304, 32'h04030201);
    res_word(32'ha1b2c3d4, 32'hd4c3b2a1);
    apb(1'b1, OFF_CONTROL, 32'h00010800);
    res_word(32'ha1b2c3d4, 32'ha1b2c3d4);
    // Single-block results skip the packet byte order.
    apb(1'b1, OFF_CONTROL, 32'h00010010);
    res_word(32'ha1b2c3d4, 32'ha1b2c3d4);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_IMASK, 32'(1 << i));
      pulse(4'(1 << i));
      chk(irq, 1'b1);
      rdc(OFF_ISTAT, 32'(1 << i));
      apb(1'b1, OFF_ISTAT, 32'(1 << i));
      pulse(4'h0);
      chk(irq, 1'b0);
    end
    apb(1'b1, OFF_IMASK, 32'h0);
    pulse(4'h8);
    chk(irq, 1'b0);
    rdc(OFF_ISTAT, 32'h8);
    complete_run();
  end
endmodule
